/* File: src/pjd_pkg.sv */
// Shared constants and types for the paper jam detector.
package pjd_pkg;
  // ************************************************************
  // Clock and times
  // ************************************************************
  localparam int CLK_KHZ          = 100000;
  localparam int TRAY_TMO_MS      = 1000;
  localparam int STAPLE_TMO_MS    = 500;
  localparam int PUNCH_TMO_MS     = 200;
  localparam int TRAY_TMO_CYC     = TRAY_TMO_MS * CLK_KHZ;
  localparam int STAPLE_TMO_CYC   = STAPLE_TMO_MS * CLK_KHZ;
  localparam int PUNCH_TMO_CYC    = PUNCH_TMO_MS * CLK_KHZ;
  localparam logic [2:0] SETTLE_CYC = 3'h4;

  // ************************************************************
  // Feed distances in millimetres
  // ************************************************************
  localparam logic [15:0] INLET_DELAY_MM  = 16'd400;
  localparam logic [15:0] BUFFER_DELAY_MM = 16'd550;
  localparam logic [15:0] DLV_STRAIGHT_MM = 16'd476;
  localparam logic [15:0] DLV_BUFFER_MM   = 16'd772;

  // ************************************************************
  // Register map and fields
  // ************************************************************
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_SHEET_LEN = 4'h4;
  localparam logic [3:0] REG_SCALE     = 4'h8;
  localparam logic [3:0] REG_STATUS    = 4'hc;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_BUFFER = 1;
  localparam int CTRL_PUNCH  = 2;
  localparam int CTRL_CLEAR  = 3;
  localparam logic [2:0]  CTRL_RESET      = 3'h0;
  localparam logic [15:0] SHEET_LEN_RESET = 16'h012a;
  localparam logic [7:0]  SCALE_RESET     = 8'h01;
  localparam int STAT_JAM     = 16;
  localparam int STAT_REFUSED = 17;
  localparam int STAT_CAUSE   = 20;

  // ************************************************************
  // Synchronised pin vector positions
  // ************************************************************
  localparam int NPIN = 14;
  localparam int P_INLET = 0, P_DLV = 1, P_TRAY = 2, P_BUFP = 3, P_BUFE = 4;
  localparam int P_STHOME = 5, P_JOINT = 6, P_DOOR = 7, P_ILOCK = 8, P_PDOOR = 9;
  localparam int P_PHOME = 10, P_HDLV = 11, P_START = 12, P_FEED = 13;

  // ************************************************************
  // Jam causes, one flag bit each; cause code is bit index plus one
  // ************************************************************
  localparam int NJAM = 13;
  localparam int J_INLET_DLY = 0, J_INLET_STAT = 1, J_BUF_DLY = 2, J_BUF_STAT = 3;
  localparam int J_DLV_DLY = 4, J_DLV_STAT = 5, J_TRAY_STAT = 6, J_TIMING = 7;
  localparam int J_STAPLE = 8, J_POWER = 9, J_DOOR = 10, J_PUNCH = 11, J_STAY = 12;

  // Clearance check states, Gray coded along the path.
  typedef enum logic [1:0] {
    PJD_CL_IDLE  = 2'b00,
    PJD_CL_CHECK = 2'b01,
    PJD_CL_DONE  = 2'b11
  } pjd_clear_t;
endpackage : pjd_pkg

/* File: src/pjd_top.sv */
// Paper jam detector: sensor windows, jam flags, clearance check, Wishbone registers.
//
// Functional notes
// - Jam is sensor presence compared against expected state at feed points.
// - Any jam halts delivery and signals the host.
// - Clearance with doors closed rechecks path sensors; paper resends removal request.
// - Upper and lower tray paper sensors never take part in jam checks.
// - Inlet delay jam: no inlet paper within 400 mm after host delivery.
// - Inlet stationary jam: inlet still on after twice sheet length.
// - Buffer delay jam: no buffer sensor paper within 550 mm after inlet on.
// - Buffer stationary jam: buffer sensor still on after twice sheet length.
// - Straight path delivery delay jam: no delivery paper within 476 mm.
// - Buffer path delivery delay jam: no delivery paper within 772 mm.
// - Delivery stationary jam: delivery sensor on after twice sheet length.
// - Stapling tray jam: sheet not cleared 1 s after delivery motor on.
// - Timing jam: inlet sees a sheet before host delivery signal.
// - Staple jam: home sensor not back within 0.5 s in forward rotation.
// - Power-on jam: any path sensor except the buffer path sensor sees paper at power-up.
// - Door open jam during operation, puncher door included when fitted.
// - Punch jam: punch home not back on within 200 ms.
// - Host holds start signal while feeding; a drop flags a stay jam.
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pjd_top
  import pjd_pkg::*;
#(
  parameter int TRAY_TMO   = TRAY_TMO_CYC,
  parameter int STAPLE_TMO = STAPLE_TMO_CYC,
  parameter int PUNCH_TMO  = PUNCH_TMO_CYC
) (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Wishbone slave.
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Paper sensors, high when paper is present.
  input  wire logic        inlet_paper_sensor_in,
  input  wire logic        delivery_paper_sensor_in,
  input  wire logic        staple_tray_paper_sensor_in,
  input  wire logic        buffer_path_paper_sensor_in,
  input  wire logic        buffer_entry_paper_sensor_in,
  input  wire logic        upper_tray_paper_sensor_in,
  input  wire logic        lower_tray_paper_sensor_in,
  // Home sensors, high at home; door inputs, high when open.
  input  wire logic        staple_home_sensor_in,
  input  wire logic        punch_home_sensor_in,
  input  wire logic        joint_sensor_in,
  input  wire logic        door_open_sensor_in,
  input  wire logic        door_interlock_switch_in,
  input  wire logic        puncher_front_door_switch_in,
  // Host signals and feed motor pulses.
  input  wire logic        host_delivery_in,
  input  wire logic        finisher_start_in,
  input  wire logic        feed_pulse_in,
  // Motor commands from the local sequencer, same clock.
  input  wire logic        delivery_drive_motor_on_in,
  input  wire logic        staple_drive_motor_fwd_in,
  // Outputs to the host and the sequencer.
  output logic             jam_out,
  output logic             delivery_halt_out,
  output logic             removal_request_out
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [NPIN-1:0] pins, s1, s2, s3, pin, pin_d;
  logic [15:0] sheet_len;
  logic [7:0]  scale, pulse_cnt;
  logic [2:0]  ctrl;
  logic [NJAM-1:0] flags, set_jam;
  logic [3:0]  cause;
  logic        refused, clear_pulse, mm_tick, any_jam, expect_sheet, feeding;
  logic [2:0]  po_cnt;
  logic        po_done;
  pjd_clear_t  cl_state;

  // Upper and lower tray sensors are not gathered here.
  // tray sensors excluded
  assign pins = {feed_pulse_in, finisher_start_in, host_delivery_in, punch_home_sensor_in,
                 puncher_front_door_switch_in, door_interlock_switch_in,
                 door_open_sensor_in, joint_sensor_in, staple_home_sensor_in,
                 buffer_entry_paper_sensor_in, buffer_path_paper_sensor_in,
                 staple_tray_paper_sensor_in, delivery_paper_sensor_in,
                 inlet_paper_sensor_in};

  // Three stages per pin; a level is taken only once stages two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          s1[gi]    <= 1'b0;
          s2[gi]    <= 1'b0;
          s3[gi]    <= 1'b0;
          pin[gi]   <= 1'b0;
          pin_d[gi] <= 1'b0;
        end else begin
          s1[gi] <= pins[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            pin[gi] <= s3[gi];
          end
          pin_d[gi] <= pin[gi];
        end
      end
    end
  endgenerate

  logic [NPIN-1:0] rise, fall;
  assign rise = pin & ~pin_d;
  assign fall = ~pin & pin_d;
  assign any_jam = |flags;

  // ************************************************************
  // Feed distance scaling
  // ************************************************************
  // pulses to mm
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pulse_cnt <= 8'h00;
      mm_tick   <= 1'b0;
    end else begin
      mm_tick <= 1'b0;
      if (rise[P_FEED]) begin
        if (pulse_cnt + 8'h01 >= scale) begin
          pulse_cnt <= 8'h00;
          mm_tick   <= 1'b1;
        end else begin
          pulse_cnt <= pulse_cnt + 8'h01;
        end
      end
    end
  end

  // ************************************************************
  // Distance windows, one counter each
  // ************************************************************
  logic [5:0]  w_start, w_stop, w_active, w_hit;
  logic [15:0] w_limit [6];
  logic [15:0] w_cnt   [6];
  logic        run;
  assign run = ctrl[CTRL_ENABLE] & ~any_jam;

  // Expected presence points along the feed.
  // sensor versus expected
  always_comb begin
    w_start = '0;
    w_stop  = '0;
    w_start[J_INLET_DLY]  = rise[P_HDLV];
    w_stop[J_INLET_DLY]   = rise[P_INLET];
    w_start[J_INLET_STAT] = rise[P_INLET];
    w_stop[J_INLET_STAT]  = fall[P_INLET];
    w_start[J_BUF_DLY]    = rise[P_INLET] & ctrl[CTRL_BUFFER];
    w_stop[J_BUF_DLY]     = rise[P_BUFP];
    w_start[J_BUF_STAT]   = rise[P_BUFP];
    w_stop[J_BUF_STAT]    = fall[P_BUFP];
    w_start[J_DLV_DLY]    = rise[P_INLET];
    w_stop[J_DLV_DLY]     = rise[P_DLV];
    w_start[J_DLV_STAT]   = rise[P_DLV];
    w_stop[J_DLV_STAT]    = fall[P_DLV];
  end

  // Stationary limits use twice the programmed sheet length.
  assign w_limit[J_INLET_DLY]  = INLET_DELAY_MM;
  assign w_limit[J_INLET_STAT] = {sheet_len[14:0], 1'b0};
  assign w_limit[J_BUF_DLY]    = BUFFER_DELAY_MM;
  assign w_limit[J_BUF_STAT]   = {sheet_len[14:0], 1'b0};
  assign w_limit[J_DLV_DLY]    = ctrl[CTRL_BUFFER] ? DLV_BUFFER_MM : DLV_STRAIGHT_MM;
  assign w_limit[J_DLV_STAT]   = {sheet_len[14:0], 1'b0};

  // A start restarts the window even if a stop comes in the same cycle.
  generate
    for (gi = 0; gi < 6; gi++) begin : g_win
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          w_active[gi] <= 1'b0;
          w_cnt[gi]    <= 16'h0000;
        end else if (!run) begin
          w_active[gi] <= 1'b0;
          w_cnt[gi]    <= 16'h0000;
        end else if (w_start[gi]) begin
          w_active[gi] <= 1'b1;
          w_cnt[gi]    <= 16'h0000;
        end else if (w_stop[gi] || w_hit[gi]) begin
          w_active[gi] <= 1'b0;
        end else if (mm_tick && w_cnt[gi] != 16'hffff) begin
          w_cnt[gi] <= w_cnt[gi] + 16'h0001;
        end
      end
      assign w_hit[gi] = w_active[gi] & ~w_stop[gi] & (w_cnt[gi] >= w_limit[gi]);
    end
  endgenerate

  // ************************************************************
  // Time windows: stapling tray, staple, punch
  // ************************************************************
  logic [2:0]  t_start, t_stop, t_active, t_hit;
  logic [31:0] t_cnt [3];
  logic [31:0] t_limit [3];
  assign t_limit[0] = 32'(TRAY_TMO);
  assign t_limit[1] = 32'(STAPLE_TMO);
  assign t_limit[2] = 32'(PUNCH_TMO);
  logic motor_d;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      motor_d <= 1'b0;
    end else begin
      motor_d <= delivery_drive_motor_on_in;
    end
  end

  assign t_start[0] = delivery_drive_motor_on_in & ~motor_d & pin[P_TRAY];
  assign t_stop[0]  = ~pin[P_TRAY];
  assign t_start[1] = fall[P_STHOME] & staple_drive_motor_fwd_in;
  assign t_stop[1]  = rise[P_STHOME];
  assign t_start[2] = fall[P_PHOME] & ctrl[CTRL_PUNCH];
  assign t_stop[2]  = rise[P_PHOME];

  generate
    for (gi = 0; gi < 3; gi++) begin : g_tmr
      always_ff @(posedge clk_in) begin
        if (rst_in || !run) begin
          t_active[gi] <= 1'b0;
          t_cnt[gi]    <= 32'h0000_0000;
        end else if (t_start[gi]) begin
          t_active[gi] <= 1'b1;
          t_cnt[gi]    <= 32'h0000_0001;
        end else if (t_stop[gi] || t_hit[gi]) begin
          t_active[gi] <= 1'b0;
        end else if (t_active[gi]) begin
          t_cnt[gi] <= t_cnt[gi] + 32'h0000_0001;
        end
      end
      assign t_hit[gi] = t_active[gi] & ~t_stop[gi] & (t_cnt[gi] >= t_limit[gi]);
    end
  endgenerate

  // ************************************************************
  // Event jams: timing, power-on, door, stay
  // ************************************************************
  // The host delivery announcement is held until the inlet sees the sheet.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      expect_sheet <= 1'b0;
    end else if (rise[P_HDLV]) begin
      expect_sheet <= 1'b1;
    end else if (rise[P_INLET]) begin
      expect_sheet <= 1'b0;
    end
  end

  // Power-up check waits for the synchronisers to fill first.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      po_cnt  <= 3'h0;
      po_done <= 1'b0;
    end else if (!po_done) begin
      po_cnt  <= po_cnt + 3'h1;
      po_done <= (po_cnt == SETTLE_CYC);
    end
  end

  logic path_paper, door_open;
  assign path_paper = pin[P_INLET] | pin[P_DLV] | pin[P_TRAY] | pin[P_BUFP] | pin[P_BUFE];
  assign door_open  = pin[P_JOINT] | pin[P_DOOR] | pin[P_ILOCK] |
                      (ctrl[CTRL_PUNCH] & pin[P_PDOOR]);
  assign feeding    = |w_active | expect_sheet | path_paper;

  always_comb begin
    set_jam = '0;
    set_jam[5:0] = w_hit;
    set_jam[J_TRAY_STAT] = t_hit[0];
    set_jam[J_STAPLE]    = t_hit[1];
    set_jam[J_PUNCH]     = t_hit[2];
    set_jam[J_TIMING] = run & rise[P_INLET] & ~expect_sheet & ~rise[P_HDLV];
    set_jam[J_POWER]  = ~po_done & (po_cnt == SETTLE_CYC) &
                        (pin[P_INLET] | pin[P_DLV] | pin[P_TRAY] | pin[P_BUFE]);
    set_jam[J_DOOR]   = ctrl[CTRL_ENABLE] & door_open;
    set_jam[J_STAY]   = run & fall[P_START] & feeding;
  end

  // ************************************************************
  // Jam flags, cause code and host outputs
  // ************************************************************
  logic clear_ok;
  assign clear_ok = (cl_state == PJD_CL_CHECK) & ~door_open & ~path_paper;

  // New jams beat a clearance in the same cycle.
  // latch until cleared
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags <= '0;
      cause <= 4'h0;
    end else begin
      flags <= (clear_ok ? '0 : flags) | set_jam;
      if ((!any_jam || clear_ok) && |set_jam) begin
        for (int i = NJAM - 1; i >= 0; i--) begin
          if (set_jam[i]) begin
            cause <= 4'(i + 1);
          end
        end
      end else if (clear_ok) begin
        cause <= 4'h0;
      end
    end
  end

  // Halt and report follow the flags one cycle later.
  // halt and report
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      jam_out           <= 1'b0;
      delivery_halt_out <= 1'b0;
    end else begin
      jam_out           <= any_jam;
      delivery_halt_out <= any_jam;
    end
  end

  // ************************************************************
  // Clearance check
  // ************************************************************
  // recheck after removal
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cl_state            <= PJD_CL_IDLE;
      removal_request_out <= 1'b0;
      refused             <= 1'b0;
    end else begin
      removal_request_out <= 1'b0;
      case (cl_state)
        PJD_CL_IDLE: begin
          if (clear_pulse && any_jam) begin
            cl_state <= PJD_CL_CHECK;
          end
        end
        PJD_CL_CHECK: begin
          cl_state <= PJD_CL_DONE;
          refused  <= door_open;
          if (!door_open && path_paper) begin
            removal_request_out <= 1'b1;
          end
        end
        PJD_CL_DONE: begin
          cl_state <= PJD_CL_IDLE;
        end
        default: begin
          cl_state <= PJD_CL_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Wishbone registers
  // ************************************************************
  logic wb_req;
  assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;

  // Writes land on the same edge that raises the acknowledge, one per request.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl        <= CTRL_RESET;
      sheet_len   <= SHEET_LEN_RESET;
      scale       <= SCALE_RESET;
      clear_pulse <= 1'b0;
    end else begin
      clear_pulse <= 1'b0;
      if (wb_req && wb_we_in) begin
        case (wb_adr_in)
          REG_CTRL: begin
            if (wb_sel_in[0]) begin
              ctrl        <= wb_dat_in[2:0];
              clear_pulse <= wb_dat_in[CTRL_CLEAR];
            end
          end
          REG_SHEET_LEN: begin
            if (wb_sel_in[0]) sheet_len[7:0]  <= wb_dat_in[7:0];
            if (wb_sel_in[1]) sheet_len[15:8] <= wb_dat_in[15:8];
          end
          REG_SCALE: begin
            if (wb_sel_in[0]) scale <= wb_dat_in[7:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Unmapped offsets read as zero and still acknowledge.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_req;
      if (wb_req && !wb_we_in) begin
        case (wb_adr_in)
          REG_CTRL:      wb_dat_out <= {29'h0, ctrl};
          REG_SHEET_LEN: wb_dat_out <= {16'h0, sheet_len};
          REG_SCALE:     wb_dat_out <= {24'h0, scale};
          REG_STATUS:    wb_dat_out <= {8'h0, cause, 2'h0, refused, any_jam, 3'h0, flags};
          default:       wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_HALT_FOLLOWS: assert property (any_jam |=> delivery_halt_out && jam_out)
    else $error("delivery not halted after a jam flag");
  AST_FLAG_STICKY: assert property (flags[J_DOOR] && cl_state != PJD_CL_CHECK
    |=> flags[J_DOOR])
    else $error("jam flag dropped without a clearance check");
  AST_INLET_DELAY: assert property (run && w_active[0] && w_cnt[0] >= 16'd400 && !w_stop[0]
    |=> flags[J_INLET_DLY])
    else $error("inlet delay jam missed at 400 mm");
  AST_DLV_LIMIT: assert property (w_limit[J_DLV_DLY] == (ctrl[CTRL_BUFFER] ? 16'd772 :
    16'd476))
    else $error("delivery delay limit wrong for path");
  AST_NO_EARLY_DLY: assert property (w_hit[J_DLV_DLY] |->
    w_cnt[J_DLV_DLY] >= (ctrl[CTRL_BUFFER] ? 16'd772 : 16'd476))
    else $error("delivery delay jam before its distance");
  AST_TIMING: assert property (run && rise[P_INLET] && !expect_sheet && !rise[P_HDLV]
    |=> flags[J_TIMING])
    else $error("timing jam not flagged");
  AST_STAY: assert property (run && fall[P_START] && feeding |=> flags[J_STAY])
    else $error("stay jam not flagged");
  AST_RESEND: assert property (cl_state == PJD_CL_CHECK && !door_open && path_paper
    |=> removal_request_out ##1 !removal_request_out && any_jam)
    else $error("removal request not resent with paper present");
  AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("acknowledge held longer than one cycle");
  AST_DOOR: assert property (ctrl[CTRL_ENABLE] && pin[P_ILOCK] |=> flags[J_DOOR])
    else $error("door open jam not flagged");
endmodule : pjd_top
`default_nettype wire

/* File: tb/pjd_host_model.sv */
// Host controller model: delivery signal, start level and feed motor pulses.
`timescale 1ns/1ps
`default_nettype none
module pjd_host_model (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Commands from the bench.
  input  wire logic        go_in,
  input  wire logic        announce_in,
  input  wire logic [15:0] pulses_in,
  input  wire logic        stop_in,
  // Host side pins.
  output logic             host_delivery_out,
  output logic             finisher_start_out,
  output logic             feed_pulse_out,
  output logic             busy_out
);
  logic [15:0] cnt;
  logic [2:0]  ph;

  // Pulses are four cycles high and four low, safely above the input filter.
  assign feed_pulse_out = ph[2];
  assign busy_out       = (cnt != 16'h0);

  // start held: reset clears start, it rises the cycle after reset and stays up unless the bench drops it between feeds.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt                <= 16'h0;
      ph                 <= 3'h0;
      host_delivery_out  <= 1'b0;
      finisher_start_out <= 1'b0;
    end else if (go_in) begin
      cnt               <= pulses_in;
      host_delivery_out <= announce_in;
    end else if (cnt != 16'h0) begin
      finisher_start_out <= 1'b1;
      ph                 <= ph + 3'h1;
      if (ph == 3'h7) cnt <= cnt - 16'h1;
    end else begin
      finisher_start_out <= ~stop_in;
    end
  end
endmodule : pjd_host_model
`default_nettype wire

/* File: tb/test_paper_jam_detector.sv */
// Self-checking bench for the paper jam detector.
`timescale 1ns/1ps
`default_nettype none
module test_paper_jam_detector;
  import pjd_pkg::*;
  logic clk_in = 0, rst_in = 1, cyc = 0, stb = 0, we = 0, go = 0, ann = 0, trays = 0;
  logic sth = 1, phm = 1, mot = 0, fwd = 0, stp = 0;
  logic [3:0]  adr = 4'h0, door = 4'h0;
  logic [4:0]  pth = 5'h0;
  logic [15:0] npul = 16'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic        ack, jam, halt, rmv, hd, st, fp, busy;
  int          failures = 0, n_tests = 0, n_rmv = 0, k, d;

  initial forever #5 clk_in = ~clk_in;

  pjd_top #(.TRAY_TMO(50), .STAPLE_TMO(30), .PUNCH_TMO(20)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack),
    .inlet_paper_sensor_in(pth[0]), .delivery_paper_sensor_in(pth[1]),
    .staple_tray_paper_sensor_in(pth[2]), .buffer_path_paper_sensor_in(pth[3]),
    .buffer_entry_paper_sensor_in(pth[4]), .upper_tray_paper_sensor_in(trays),
    .lower_tray_paper_sensor_in(trays), .staple_home_sensor_in(sth),
    .punch_home_sensor_in(phm), .joint_sensor_in(door[0]), .door_open_sensor_in(door[1]),
    .door_interlock_switch_in(door[2]), .puncher_front_door_switch_in(door[3]),
    .host_delivery_in(hd), .finisher_start_in(st), .feed_pulse_in(fp),
    .delivery_drive_motor_on_in(mot), .staple_drive_motor_fwd_in(fwd),
    .jam_out(jam), .delivery_halt_out(halt), .removal_request_out(rmv));

  pjd_host_model host_u (.clk_in(clk_in), .rst_in(rst_in), .go_in(go), .announce_in(ann),
    .pulses_in(npul), .stop_in(stp), .host_delivery_out(hd), .finisher_start_out(st),
    .feed_pulse_out(fp), .busy_out(busy));

  // The removal request is a one-cycle pulse, so it is counted rather than polled.
  always @(posedge clk_in) if (rmv === 1'b1) n_rmv++;

  task automatic results();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One classic cycle; the request is held until ack is sampled high.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] dw);
    int i;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= dw;
    i = 0;
    do begin @(posedge clk_in); i++; end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin failures++; results(); end
    rdat = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk_in);
  endtask : bus

  task automatic wj(input logic e);
    int i;
    for (i = 0; i < 40 && jam !== e; i++) @(posedge clk_in);
    chk("jam", {31'h0, e}, {31'h0, jam});
    chk("halt", {31'h0, e}, {31'h0, halt});
  endtask : wj

  task automatic feed(input logic a, input logic [15:0] n);
    int i;
    ann <= a; npul <= n; go <= 1;
    @(posedge clk_in);
    go <= 0;
    @(posedge clk_in);
    for (i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk_in);
    if (busy !== 1'b0) begin failures++; results(); end
    repeat (10) @(posedge clk_in);
  endtask : feed

  // Waits, checks that no jam came early, then expects the one flag and its cause.
  task automatic jt(input int b, input int w);
    repeat (w) @(posedge clk_in);
    chk("early", 0, jam);
    wj(1);
    bus(0, REG_STATUS, 0);
    chk("status", sx(b), rdat);
  endtask : jt

  // Lets the pins settle through the filter, then clears with the given control value.
  task automatic clr(input logic [31:0] c);
    repeat (8) @(posedge clk_in);
    bus(1, REG_CTRL, c);
    wj(0);
  endtask : clr

  function automatic logic [31:0] sx(input int b);
    sx = 32'h0;
    sx[b] = 1'b1;
    sx[STAT_JAM] = 1'b1;
    sx[STAT_CAUSE +: 4] = 4'(b + 1);
  endfunction : sx

  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 0;
    repeat (20) @(posedge clk_in);
    bus(0, REG_SHEET_LEN, 0); chk("len", 32'h12a, rdat);
    bus(0, REG_SCALE, 0); chk("scale", 32'h1, rdat);
    bus(1, 4'h2, 32'hffff); bus(0, 4'h2, 0); chk("unmapped", 32'h0, rdat);
    bus(1, REG_CTRL, 32'h1);
    pth[0] <= 1; wj(1);
    bus(0, REG_STATUS, 0); chk("status", sx(J_TIMING), rdat);
    k = n_rmv; bus(1, REG_CTRL, 32'h9); repeat (10) @(posedge clk_in);
    chk("removal", k + 1, n_rmv);
    wj(1);
    pth[0] <= 0; repeat (8) @(posedge clk_in); bus(1, REG_CTRL, 32'h9); wj(0);
    $display("done timing and clearance");
    feed(1, 16'd399); chk("jam399", 0, jam);
    feed(1, 16'd1); wj(1);
    bus(0, REG_STATUS, 0); chk("status", sx(J_INLET_DLY), rdat);
    bus(1, REG_CTRL, 32'h9); wj(0);
    $display("done inlet delay");
    trays <= 1; repeat (20) @(posedge clk_in); chk("trays", 0, jam);
    pth[2] <= 1; repeat (8) @(posedge clk_in); mot <= 1; jt(J_TRAY_STAT, 45);
    mot <= 0; pth[2] <= 0; clr(32'h9);
    fwd <= 1; sth <= 0; jt(J_STAPLE, 20);
    fwd <= 0; sth <= 1; clr(32'h9);
    stp <= 1; jt(J_STAY, 1);
    stp <= 0; clr(32'h9);
    $display("done tray, staple and stay");
    bus(1, REG_CTRL, 32'h5);
    for (d = 0; d < 4; d++) begin
      door <= 4'(1 << d); wj(1);
      bus(1, REG_CTRL, 32'hd); repeat (4) @(posedge clk_in);
      bus(0, REG_STATUS, 0); chk("refused", 1, rdat[STAT_REFUSED]);
      door <= 0; repeat (8) @(posedge clk_in); bus(1, REG_CTRL, 32'hd); wj(0);
    end
    phm <= 0; jt(J_PUNCH, 12);
    phm <= 1; clr(32'hd);
    $display("done doors and punch");
    foreach (pth[j]) begin
      if (j == 3) continue;
      pth <= 5'(1 << j) | 5'h08; rst_in <= 1; repeat (2) @(posedge clk_in);
      rst_in <= 0; repeat (20) @(posedge clk_in);
      bus(0, REG_STATUS, 0); chk("poweron", sx(J_POWER), rdat);
    end
    $display("done power-on");
    results();
  end
endmodule : test_paper_jam_detector
`default_nettype wire
